//--- core/prbst_pkg.sv
`default_nettype none
package prbst_pkg;

   // Port geometry
   localparam int PORT_W = 8;
   localparam int CH_W = 4;
   localparam int AVS_AW = 8;
   localparam int AVS_DW = 32;
   localparam int AVS_BEW = 4;

   // Register byte offsets
   localparam logic [AVS_AW-1:0] OFF_KEY = 8'h00;
   localparam logic [AVS_AW-1:0] OFF_DATA = 8'h04;
   localparam logic [AVS_AW-1:0] OFF_DIR = 8'h08;
   localparam logic [AVS_AW-1:0] OFF_PORT = 8'h0C;
   localparam logic [AVS_AW-1:0] OFF_FUNC = 8'h10;
   localparam logic [AVS_AW-1:0] OFF_RSTPIN = 8'h14;
   localparam logic [AVS_AW-1:0] OFF_ADCSEL = 8'h18;
   localparam logic [AVS_AW-1:0] OFF_BITOP = 8'h1C;
   localparam logic [AVS_AW-1:0] OFF_WAKEEN = 8'h20;
   localparam logic [AVS_AW-1:0] OFF_STATUS = 8'h24;

   // Key that switches reads to raw pin levels
   localparam logic [7:0] READBACK_KEY = 8'hCA;
   localparam logic [7:0] KEY_RST = 8'h00;

   // Reset values, replicated per pin
   localparam logic DATA_RST_BIT = 1'b1;
   localparam logic DIR_RST_BIT = 1'b1;
   localparam logic CLR_BIT = 1'b0;

   // Status field positions
   localparam int STAT_MODE_POS = 0;
   localparam int STAT_SLEEP_POS = 1;

   typedef enum logic [1:0] {
      FUNC_GPIO,
      FUNC_DOUT,
      FUNC_SERIAL,
      FUNC_ANALOG
   } prbst_func_t;

   // Single-bit set or clear command word
   typedef struct packed {
      logic [21:0] rsvd_hi;
      logic value;
      logic target_dir;
      logic [2:0] rsvd_lo;
      logic [4:0] index;
   } prbst_bitop_t;

   function automatic prbst_func_t prbst_to_func(input logic [1:0] code);
      return prbst_func_t'(code);
   endfunction : prbst_to_func

endpackage : prbst_pkg
`default_nettype wire

//--- core/prbst_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module prbst_pin_sync #(
   parameter int W = prbst_pkg::PORT_W
) (
   input wire logic clk_i, // System clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic [W-1:0] pin_i, // Raw pin levels
   output logic [W-1:0] level_o, // Synchronised levels
   output logic [W-1:0] fall_o // High-to-low seen, one cycle
);
   import prbst_pkg::*;

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] prev_reg;

   // Pins start high so no false falling edge after reset
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_reg <= {W{DATA_RST_BIT}};
         sync_reg <= {W{DATA_RST_BIT}};
         prev_reg <= {W{DATA_RST_BIT}};
      end
      else
      begin
         meta_reg <= pin_i;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign level_o = sync_reg;
   assign fall_o = prev_reg & ~sync_reg;

endmodule : prbst_pin_sync
`default_nettype wire

//--- core/prbst_read_mux.sv
`timescale 1ns/1ns
`default_nettype none
module prbst_read_mux #(
   parameter int W = prbst_pkg::PORT_W
) (
   input wire logic mode_i, // Readback mode active
   input wire logic [W-1:0] pin_i, // Synchronised pin levels
   input wire logic [W-1:0] data_i, // Output latch
   input wire logic [W-1:0] dir_i, // Direction, 1 = input
   input wire logic [2*W-1:0] func_i, // Function code per pin
   input wire logic [W-1:0] rst_pin_i, // Pin carries external reset
   output logic [W-1:0] rd_o // Value a port read returns
);
   import prbst_pkg::*;

   always_comb
   begin
      rd_o = '0;
      for (int i = 0; i < W; i++)
      begin
         if (rst_pin_i[i] || prbst_to_func(func_i[2*i +: 2]) == FUNC_ANALOG)
            rd_o[i] = CLR_BIT;
         else if (mode_i)
            rd_o[i] = pin_i[i];
         else
         begin
            unique case (prbst_to_func(func_i[2*i +: 2]))
               FUNC_GPIO: rd_o[i] = pin_i[i];
               FUNC_DOUT: rd_o[i] = dir_i[i] ? CLR_BIT : data_i[i];
               FUNC_SERIAL: rd_o[i] = dir_i[i] ? pin_i[i] : data_i[i];
               FUNC_ANALOG: rd_o[i] = CLR_BIT;
            endcase
         end
      end
   end

endmodule : prbst_read_mux
`default_nettype wire

//--- core/prbst_top.sv
// Operation
// - Readback mode is on only while the key register holds 11001010.
// - With readback off, each pin follows its selected shared function.
// - With readback on, port reads return pin levels for digital pins not carrying external reset.
// - Normal reads: I/O pin level; output 0 or latch; serial pin or latch.
// - Normal reads return 0 for analog or external reset pins.
// - Normal mode keeps the analog path open unless analog function selected.
// - Analog channel connects only when selected and pin set to analog or readback on.
// - Readback mode forces the selected channel path closed for loop-back.
// - Reset sets all data and direction bits high.
// - Bit set or clear on data reads the port, modifies one bit, writes it back; on direction it modifies the direction register.
// - Falling edge on a wake-enabled Port A pin wakes from sleep or idle.
`timescale 1ns/1ns
`default_nettype none
module prbst_top #(
   parameter int PW = prbst_pkg::PORT_W, // Port width, at most 2**CH_W
   parameter int CHW = prbst_pkg::CH_W // Converter channel select width
) (
   input wire logic CLK_I, // System clock, 50 MHz
   input wire logic RST_N_I, // Async reset, active low
   input wire logic [prbst_pkg::AVS_AW-1:0] AVS_ADDRESS_I, // Byte address
   input wire logic AVS_READ_I, // Read request
   input wire logic AVS_WRITE_I, // Write request
   input wire logic [prbst_pkg::AVS_DW-1:0] AVS_WRITEDATA_I, // Write data
   input wire logic [prbst_pkg::AVS_BEW-1:0] AVS_BYTEENABLE_I, // Byte lanes
   output logic [prbst_pkg::AVS_DW-1:0] AVS_READDATA_O, // Read data
   output logic AVS_WAITREQUEST_O, // Stall, active high
   input wire logic [PW-1:0] PIN_I, // Pad input levels
   output logic [PW-1:0] PIN_OUT_O, // Pad output levels
   output logic [PW-1:0] PIN_OE_O, // Pad drive enable, high drives
   input wire logic [PW-1:0] PERIPH_OUT_I, // Shared function output data
   input wire logic [PW-1:0] PERIPH_OE_I, // Shared function drive enable
   output logic [PW-1:0] PERIPH_IN_O, // Synchronised pins to functions
   output logic [PW-1:0] ANALOG_PATH_EN_O, // Pin to converter switch closed
   input wire logic SLEEP_I, // Device in sleep or idle
   output logic WAKE_O, // Wake request, one cycle
   output logic READBACK_ACTIVE_O // Readback mode active
);
   import prbst_pkg::*;

   logic [7:0] key_reg;
   logic readback_mode_active;
   logic [PW-1:0] data_reg;
   logic [PW-1:0] dir_reg;
   logic [2*PW-1:0] func_reg;
   logic [PW-1:0] rst_pin_reg;
   logic [CHW-1:0] adc_sel_reg;
   logic [PW-1:0] wake_en_reg;
   logic wait_reg;
   logic [AVS_DW-1:0] rdata_reg;
   logic [AVS_DW-1:0] rdata_next;
   logic [PW-1:0] pin_out_reg;
   logic [PW-1:0] pin_out_next;
   logic [PW-1:0] pin_oe_reg;
   logic [PW-1:0] pin_oe_next;
   logic [PW-1:0] periph_in_reg;
   logic [PW-1:0] apath_reg;
   logic [PW-1:0] apath_next;
   logic wake_reg;
   logic [PW-1:0] pin_lvl;
   logic [PW-1:0] pin_fall;
   logic [PW-1:0] port_rd;
   logic [AVS_AW-1:0] addr_w;
   logic take;
   logic commit;
   logic [AVS_DW-1:0] wmerged;
   prbst_bitop_t bitop;
   logic [PW-1:0] bitop_data;
   logic [PW-1:0] bitop_dir;
   logic bitop_ok;

   function automatic logic [AVS_DW-1:0] be_merge(
      input logic [AVS_DW-1:0] old_w,
      input logic [AVS_DW-1:0] new_w,
      input logic [AVS_BEW-1:0] be
   );
      logic [AVS_DW-1:0] r;
      r = old_w;
      for (int b = 0; b < AVS_BEW; b++)
      begin
         if (be[b])
            r[8*b +: 8] = new_w[8*b +: 8];
      end
      return r;
   endfunction : be_merge

   function automatic logic [PW-1:0] put_bit(
      input logic [PW-1:0] v,
      input logic [4:0] idx,
      input logic val
   );
      logic [PW-1:0] r;
      r = v;
      for (int i = 0; i < PW; i++)
      begin
         if (idx == 5'(i))
            r[i] = val;
      end
      return r;
   endfunction : put_bit

   function automatic logic wr_hit(
      input logic c,
      input logic [AVS_AW-1:0] a,
      input logic [AVS_AW-1:0] off
   );
      return c && (a == off);
   endfunction : wr_hit

   prbst_pin_sync #(
      .W(PW)
   ) u_sync (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .pin_i(PIN_I),
      .level_o(pin_lvl),
      .fall_o(pin_fall)
   );

   prbst_read_mux #(
      .W(PW)
   ) u_rdmux (
      .mode_i(readback_mode_active),
      .pin_i(pin_lvl),
      .data_i(data_reg),
      .dir_i(dir_reg),
      .func_i(func_reg),
      .rst_pin_i(rst_pin_reg),
      .rd_o(port_rd)
   );

   // Bus handshake: first cycle latches read data, second commits
   assign addr_w = {AVS_ADDRESS_I[AVS_AW-1:2], 2'b00};
   assign take = (AVS_READ_I || AVS_WRITE_I) && wait_reg;
   assign commit = AVS_WRITE_I && !wait_reg;

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         wait_reg <= 1'b1;
      else
         wait_reg <= !take;
   end

   // Current word of the addressed register
   always_comb
   begin
      rdata_next = '0;
      unique case (addr_w)
         OFF_KEY: rdata_next[7:0] = key_reg;
         OFF_DATA: rdata_next[PW-1:0] = data_reg;
         OFF_DIR: rdata_next[PW-1:0] = dir_reg;
         OFF_PORT: rdata_next[PW-1:0] = port_rd;
         OFF_FUNC: rdata_next[2*PW-1:0] = func_reg;
         OFF_RSTPIN: rdata_next[PW-1:0] = rst_pin_reg;
         OFF_ADCSEL: rdata_next[CHW-1:0] = adc_sel_reg;
         OFF_WAKEEN: rdata_next[PW-1:0] = wake_en_reg;
         OFF_STATUS:
         begin
            rdata_next[STAT_MODE_POS] = readback_mode_active;
            rdata_next[STAT_SLEEP_POS] = SLEEP_I;
         end
         default: rdata_next = '0;
      endcase
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         rdata_reg <= '0;
      else if (take)
         rdata_reg <= rdata_next;
   end

   assign wmerged = be_merge(rdata_next, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         key_reg <= KEY_RST;
      else if (wr_hit(commit, addr_w, OFF_KEY))
         key_reg <= wmerged[7:0];
   end

   // Mode follows the value just written, live from the next clock
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         readback_mode_active <= 1'b0;
      else if (wr_hit(commit, addr_w, OFF_KEY))
         readback_mode_active <= (wmerged[7:0] == READBACK_KEY);
   end

   // Bit set or clear: the data latch gets the whole port read back
   assign bitop = prbst_bitop_t'(AVS_WRITEDATA_I);
   assign bitop_ok = wr_hit(commit, addr_w, OFF_BITOP) && (bitop.index < 5'(PW));
   assign bitop_data = put_bit(port_rd, bitop.index, bitop.value);
   assign bitop_dir = put_bit(dir_reg, bitop.index, bitop.value);

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         data_reg <= {PW{DATA_RST_BIT}};
      else if (wr_hit(commit, addr_w, OFF_DATA))
         data_reg <= wmerged[PW-1:0];
      else if (bitop_ok && !bitop.target_dir)
         data_reg <= bitop_data;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         dir_reg <= {PW{DIR_RST_BIT}};
      else if (wr_hit(commit, addr_w, OFF_DIR))
         dir_reg <= wmerged[PW-1:0];
      else if (bitop_ok && bitop.target_dir)
         dir_reg <= bitop_dir;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         func_reg <= '0;
         rst_pin_reg <= '0;
         adc_sel_reg <= '0;
         wake_en_reg <= '0;
      end
      else
      begin
         if (wr_hit(commit, addr_w, OFF_FUNC))
            func_reg <= wmerged[2*PW-1:0];
         if (wr_hit(commit, addr_w, OFF_RSTPIN))
            rst_pin_reg <= wmerged[PW-1:0];
         if (wr_hit(commit, addr_w, OFF_ADCSEL))
            adc_sel_reg <= wmerged[CHW-1:0];
         if (wr_hit(commit, addr_w, OFF_WAKEEN))
            wake_en_reg <= wmerged[PW-1:0];
      end
   end

   // Pad drive depends on function selection and reset-pin setting, never on readback mode
   always_comb
   begin
      pin_out_next = '0;
      pin_oe_next = '0;
      for (int i = 0; i < PW; i++)
      begin
         unique case (prbst_to_func(func_reg[2*i +: 2]))
            FUNC_GPIO:
            begin
               pin_out_next[i] = data_reg[i];
               pin_oe_next[i] = !dir_reg[i];
            end
            FUNC_DOUT, FUNC_SERIAL:
            begin
               pin_out_next[i] = PERIPH_OUT_I[i];
               pin_oe_next[i] = PERIPH_OE_I[i];
            end
            FUNC_ANALOG:
            begin
               pin_out_next[i] = CLR_BIT;
               pin_oe_next[i] = CLR_BIT;
            end
         endcase
         if (rst_pin_reg[i])
            pin_oe_next[i] = CLR_BIT;
      end
   end

   // Converter switch per pin; channel i sits on pin i
   always_comb
   begin
      apath_next = '0;
      for (int i = 0; i < PW; i++)
      begin
         if (adc_sel_reg == CHW'(i))
         begin
            if (prbst_to_func(func_reg[2*i +: 2]) == FUNC_ANALOG)
               apath_next[i] = 1'b1;
            else if (readback_mode_active)
               apath_next[i] = 1'b1;
            else
               apath_next[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         pin_out_reg <= {PW{DATA_RST_BIT}};
         pin_oe_reg <= '0;
         periph_in_reg <= '0;
         apath_reg <= '0;
      end
      else
      begin
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
         periph_in_reg <= pin_lvl;
         apath_reg <= apath_next;
      end
   end

   // Any enabled falling edge while asleep raises one wake pulse
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         wake_reg <= 1'b0;
      else
         wake_reg <= SLEEP_I && |(pin_fall & wake_en_reg);
   end

   assign AVS_READDATA_O = rdata_reg;
   assign AVS_WAITREQUEST_O = wait_reg;
   assign PIN_OUT_O = pin_out_reg;
   assign PIN_OE_O = pin_oe_reg;
   assign PERIPH_IN_O = periph_in_reg;
   assign ANALOG_PATH_EN_O = apath_reg;
   assign WAKE_O = wake_reg;
   assign READBACK_ACTIVE_O = readback_mode_active;

endmodule : prbst_top
`default_nettype wire

//--- verif/prbst_chk.sv
`timescale 1ns/1ns
`default_nettype none
module prbst_chk #(
   parameter int PW = 8,
   parameter int CHW = 4
) (
   input wire logic CLK_I, // Clock
   input wire logic RST_N_I, // Reset
   input wire logic [prbst_pkg::AVS_AW-1:0] AVS_ADDRESS_I, // Address
   input wire logic AVS_READ_I, // Read
   input wire logic AVS_WRITE_I, // Write
   input wire logic [prbst_pkg::AVS_DW-1:0] AVS_WRITEDATA_I, // Wdata
   input wire logic [prbst_pkg::AVS_BEW-1:0] AVS_BYTEENABLE_I, // Lanes
   input wire logic [prbst_pkg::AVS_DW-1:0] AVS_READDATA_O, // Rdata
   input wire logic AVS_WAITREQUEST_O, // Stall
   input wire logic [PW-1:0] PIN_OUT_O, // Pad level
   input wire logic [PW-1:0] PIN_OE_O, // Pad enable
   input wire logic [PW-1:0] ANALOG_PATH_EN_O, // Analog switch
   input wire logic SLEEP_I, // Sleep
   input wire logic WAKE_O, // Wake
   input wire logic READBACK_ACTIVE_O // Mode
);
   import prbst_pkg::*;
   logic key_wr;
   logic st_rd;
   assign key_wr = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I[7:2] == OFF_KEY[7:2] && AVS_BYTEENABLE_I[0];
   assign st_rd = AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I[7:2] == OFF_STATUS[7:2];
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   AST_WAIT_ONE: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
      else $error("request not answered after one wait cycle");
   AST_WAIT_REL: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
      else $error("waitrequest low for more than one cycle");
   AST_KEY_ON: assert property (key_wr && AVS_WRITEDATA_I[7:0] == READBACK_KEY |=> READBACK_ACTIVE_O)
      else $error("matching key did not enter readback");
   AST_KEY_OFF: assert property (key_wr && AVS_WRITEDATA_I[7:0] != READBACK_KEY |=> !READBACK_ACTIVE_O)
      else $error("other key did not leave readback");
   AST_MODE_HOLD: assert property ($changed(READBACK_ACTIVE_O) |-> $past(key_wr))
      else $error("readback changed without a key write");
   AST_PATH_ONE: assert property (ANALOG_PATH_EN_O != '0 |-> $onehot(ANALOG_PATH_EN_O))
      else $error("more than one analog path closed");
   AST_WAKE_SLEEP: assert property (WAKE_O |-> $past(SLEEP_I))
      else $error("wake outside sleep");
   AST_RST_PADS: assert property ($rose(RST_N_I) |-> PIN_OE_O == '0 && &PIN_OUT_O && !READBACK_ACTIVE_O)
      else $error("pads not at reset state");
   AST_STAT_RD: assert property (st_rd |-> AVS_READDATA_O == {30'h0000_0000, $past(SLEEP_I), READBACK_ACTIVE_O})
      else $error("status read wrong");
   COV_MODE: cover property (key_wr ##1 READBACK_ACTIVE_O);
   COV_WAKE: cover property (WAKE_O);
   COV_LOOP: cover property (READBACK_ACTIVE_O && ANALOG_PATH_EN_O != '0);
endmodule : prbst_chk
bind prbst_top prbst_chk #(.PW(PW), .CHW(CHW)) u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
   .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
   .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
   .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .PIN_OUT_O(PIN_OUT_O), .PIN_OE_O(PIN_OE_O),
   .ANALOG_PATH_EN_O(ANALOG_PATH_EN_O), .SLEEP_I(SLEEP_I), .WAKE_O(WAKE_O), .READBACK_ACTIVE_O(READBACK_ACTIVE_O));
`default_nettype wire

//--- verif/prbst_pins.sv
`timescale 1ns/1ns
`default_nettype none
module prbst_pins #(
   parameter int W = 8
) (
   input wire logic [W-1:0] pad_out_i, // Pad output level
   input wire logic [W-1:0] pad_oe_i, // Pad drive enable
   input wire logic [W-1:0] ext_i, // Outside circuit level
   output logic [W-1:0] pin_o // Resolved line level
);
   // Where the pad does not drive, the outside circuit holds the line
   assign pin_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule : prbst_pins
`default_nettype wire

//--- verif/prbst_bench.sv
`timescale 1ns/1ns
`default_nettype none
module prbst_bench;
   import prbst_pkg::*;
   logic clk, rst_n, rd, wr, sleep, waitreq, wake, mode_o, m_mode;
   logic [7:0] adr, pin, pout, poe, p_out, p_oe, per_in, anl, ext, m_data, m_dir, m_rst, m_key, v, tmp;
   logic [7:0] keys [8];
   logic [3:0] be, m_adc;
   logic [15:0] m_func, st;
   logic [31:0] wdat, rdat, q, cnt;
   prbst_bitop_t bo;
   int n_errors, n_compared;
   prbst_top uut (.CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(waitreq),
      .PIN_I(pin), .PIN_OUT_O(pout), .PIN_OE_O(poe), .PERIPH_OUT_I(p_out), .PERIPH_OE_I(p_oe),
      .PERIPH_IN_O(per_in), .ANALOG_PATH_EN_O(anl), .SLEEP_I(sleep), .WAKE_O(wake), .READBACK_ACTIVE_O(mode_o));
   prbst_pins pins (.pad_out_i(pout), .pad_oe_i(poe), .ext_i(ext), .pin_o(pin));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [7:0] rnd();
      repeat (8) st = lfsr(st);
      return st[7:0];
   endfunction : rnd
   function automatic logic [7:0] exp_oe();
      logic [7:0] r;
      for (int i = 0; i < 8; i++)
         r[i] = m_func[2*i+:2] == 2'h0 ? ~m_dir[i] : m_func[2*i+:2] != 2'h3 && p_oe[i];
      return r & ~m_rst;
   endfunction : exp_oe
   function automatic logic [7:0] exp_pin();
      logic [7:0] o, d;
      o = exp_oe();
      for (int i = 0; i < 8; i++)
         d[i] = m_func[2*i+:2] == 2'h0 ? m_data[i] : p_out[i];
      return (o & d) | (~o & ext);
   endfunction : exp_pin
   function automatic logic [7:0] exp_port();
      logic [7:0] p, r;
      logic [1:0] f;
      p = exp_pin();
      for (int i = 0; i < 8; i++)
      begin
         f = m_func[2*i+:2];
         r[i] = f == 2'h0 || m_mode || (f == 2'h2 && m_dir[i]) ? p[i] : !m_dir[i] && m_data[i];
         if (f == 2'h3 || m_rst[i])
            r[i] = 1'b0;
      end
      return r;
   endfunction : exp_port
   function automatic logic [7:0] exp_anl();
      logic [7:0] r;
      for (int i = 0; i < 8; i++)
         r[i] = m_adc == i && (m_func[2*i+:2] == 2'h3 || m_mode);
      return r;
   endfunction : exp_anl
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
      int n;
      n = 0;
      adr <= a;
      wdat <= d;
      be <= b;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (waitreq !== 1'b0 && n < 40)
      begin
         @(posedge clk);
         n++;
      end
      q = rdat;
      if (n == 40)
      begin
         n_errors++;
         $display("BAD %0t bus request not answered", $time);
      end
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask : wreg
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000, 4'hF);
      chk(q, e);
   endtask : rdchk
   task automatic reset_chk();
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      m_data = 8'hFF;
      m_dir = 8'hFF;
      m_key = 8'h00;
      chk(32'(poe), 32'h0000_0000);
      chk(32'(pout), 32'h0000_00FF);
      rdchk(OFF_DATA, 32'h0000_00FF);
      rdchk(OFF_DIR, 32'h0000_00FF);
      rdchk(OFF_KEY, 32'h0000_0000);
   endtask : reset_chk
   task automatic conclude();
      if (n_errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("BAD %0t watchdog expired", $time);
      conclude();
   end
   initial
   begin
      {rst_n, rd, wr, sleep, adr, be, ext, p_out, p_oe} = {4'h0, 8'h00, 4'h0, 8'hFF, 16'h0000};
      wdat = 32'h0000_0000;
      st = 16'h0031;
      keys = '{8'hCA, 8'hCB, 8'h4A, 8'h8A, 8'hCA, 8'hC8, 8'hCA, 8'h00};
      reset_chk();
      // Entry 6 masks lane 0, so the key must stay as it was
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b1, OFF_KEY, {24'hFF_FFFF, keys[i]}, i == 6 ? 4'hE : 4'hF);
         if (i != 6)
            m_key = keys[i];
         chk(32'(mode_o), 32'(m_key == READBACK_KEY));
         rdchk(OFF_STATUS, {31'h0000_0000, m_key == READBACK_KEY});
         rdchk(OFF_KEY, 32'(m_key));
      end
      for (int j = 0; j < 40; j++)
      begin
         m_data = rnd();
         m_dir = rnd();
         m_func = {rnd(), rnd()};
         m_rst = rnd() & rnd();
         m_adc = 4'(rnd());
         v = rnd();
         m_key = v[0] ? READBACK_KEY : v;
         m_mode = m_key == READBACK_KEY;
         ext <= rnd();
         p_out <= rnd();
         p_oe <= rnd();
         wreg(OFF_DATA, 32'(m_data));
         wreg(OFF_DIR, 32'(m_dir));
         wreg(OFF_FUNC, 32'(m_func));
         wreg(OFF_RSTPIN, 32'(m_rst));
         wreg(OFF_ADCSEL, 32'(m_adc));
         wreg(OFF_KEY, 32'(m_key));
         repeat (4) @(posedge clk);
         rdchk(OFF_PORT, 32'(exp_port()));
         chk(32'(poe), 32'(exp_oe()));
         chk(32'(pout & poe), 32'(exp_pin() & exp_oe()));
         chk(32'(per_in), 32'(exp_pin()));
         chk(32'(anl), 32'(exp_anl()));
         v = rnd();
         bo = '0;
         bo.index = {1'b0, v[3:0]};
         bo.target_dir = v[4];
         bo.value = v[5];
         tmp = exp_port();
         tmp[v[2:0]] = v[5];
         wreg(OFF_BITOP, bo);
         if (!v[3] && v[4])
            m_dir[v[2:0]] = v[5];
         if (!v[3] && !v[4])
            m_data = tmp;
         rdchk(OFF_DATA, 32'(m_data));
         rdchk(OFF_DIR, 32'(m_dir));
      end
      reset_chk();
      for (int i = 0; i < 3; i++)
      begin
         ext <= 8'hFF;
         sleep <= i != 2;
         wreg(OFF_WAKEEN, i == 1 ? 32'h0000_0002 : 32'h0000_0001);
         repeat (4) @(posedge clk);
         rdchk(OFF_STATUS, {30'h0000_0000, i != 2, 1'b0});
         ext <= 8'hFE;
         cnt = 0;
         repeat (8)
         begin
            @(posedge clk);
            cnt = cnt + wake;
         end
         chk(cnt, 32'(i == 0));
      end
      sleep <= 1'b0;
      wreg(8'h30, 32'hFFFF_FFFF);
      rdchk(8'h30, 32'h0000_0000);
      conclude();
   end
endmodule : prbst_bench
`default_nettype wire
